// >>> shared/sap_defs.svh
/*
  Constants of the serial audio port: default word lengths, buffer depth,
  channel encoding and counter widths.
  Assumes inclusion by bare name from every file that needs a figure.
*/
`ifndef SAP_DEFS_SVH
`define SAP_DEFS_SVH

// default sample word lengths of the two directions
`define SAP_RX_WORD_W 16
`define SAP_TX_WORD_W 16
// largest word length the bit counters can serve
`define SAP_MAX_WORD_W 32
`define SAP_CNT_W 6
// receive buffer depth in words
`define SAP_FIFO_DEPTH 16
// channel select levels
`define SAP_WS_LEFT 1'b0
`define SAP_WS_RIGHT 1'b1
// bit-count reset value
`define SAP_CNT_RST 6'h00

`endif

// >>> shared/sap_pkg.sv
/*
  Types of the serial audio port.
  Assumes nothing; used with explicit package scope only.
*/
package sap_pkg;

  // receiver framing state, gray along hunt -> run
  typedef enum logic [1:0] {
    SAP_RX_HUNT = 2'b00,
    SAP_RX_RUN = 2'b01
  } sap_rx_state_type;

  typedef enum logic {
    SAP_CH_LEFT = 1'b0,
    SAP_CH_RIGHT = 1'b1
  } sap_chan_type;

endpackage

// >>> rtl/sap_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides, width and depth as
  parameters.
  Assumes one clock, synchronous active-low reset and a clock enable.
*/
`timescale 1ns/100ps
`include "sap_defs.svh"

module sap_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = `SAP_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("sap_fifo: DEPTH must be a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o && ce_i;
  assign pop = out_valid_o && out_ready_i && ce_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end

endmodule

// >>> rtl/sap_hs_cdc.sv
/*
  Toggle handshake that carries one word between two unrelated clocks.
  Assumes the source holds off while busy; the data register is stable
  for the whole time the destination can see it.
*/
`timescale 1ns/100ps

module sap_hs_cdc #(
  parameter int WIDTH = 17
) (
  input wire logic src_clk_i,
  input wire logic src_rst_n_i,
  input wire logic src_ce_i,
  input wire logic src_valid_i,
  input wire logic [WIDTH-1:0] src_data_i,
  output logic src_busy_o,
  input wire logic dst_clk_i,
  input wire logic dst_rst_n_i,
  input wire logic dst_ce_i,
  output logic dst_valid_o,
  output logic [WIDTH-1:0] dst_data_o,
  input wire logic dst_ready_i
);

  logic [WIDTH-1:0] data_reg;
  logic req_tgl_reg;
  logic ack_s1_reg;
  logic ack_s2_reg;
  logic req_s1_reg;
  logic req_s2_reg;
  logic ack_tgl_reg;

  assign src_busy_o = (req_tgl_reg != ack_s2_reg);
  assign dst_valid_o = (req_s2_reg != ack_tgl_reg);
  assign dst_data_o = data_reg;

  always_ff @(posedge src_clk_i) begin
    if (!src_rst_n_i) begin
      data_reg <= '0;
      req_tgl_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else if (src_ce_i) begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      if (src_valid_i && !src_busy_o) begin
        data_reg <= src_data_i;
        req_tgl_reg <= ~req_tgl_reg;
      end
    end
  end

  always_ff @(posedge dst_clk_i) begin
    if (!dst_rst_n_i) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
    end else if (dst_ce_i) begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      if (dst_valid_o && dst_ready_i) begin
        ack_tgl_reg <= req_s2_reg;
      end
    end
  end

endmodule

// >>> rtl/sap_port.sv
/*
  Serial audio port, slave on the bit clock and channel select: receives
  two-channel samples into a buffered stream and transmits two-channel
  samples from a stream, on the same bit clock and channel select.
  Assumes the far end is the bus master and keeps the bit clock running
  without gaps while audio flows; the link logic runs on that clock.
*/
`timescale 1ns/100ps
`include "sap_defs.svh"

module sap_port #(
  parameter int RX_W = `SAP_RX_WORD_W,
  parameter int TX_W = `SAP_TX_WORD_W,
  parameter int FIFO_DEPTH = `SAP_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic sck_link_i,
  input wire logic ws_i,
  input wire logic sd_rx_i,
  output logic sd_tx_o,
  output logic rx_valid_o,
  output logic [RX_W-1:0] rx_data_o,
  output logic rx_chan_o,
  input wire logic rx_ready_i,
  output logic rx_drop_o,
  input wire logic tx_valid_i,
  input wire logic [TX_W-1:0] tx_data_i,
  input wire logic tx_chan_i,
  output logic tx_ready_o
);

  initial begin
    if (RX_W < 2 || RX_W > `SAP_MAX_WORD_W || TX_W < 2 || TX_W > `SAP_MAX_WORD_W) begin
      $error("sap_port: word lengths must lie in 2..32");
    end
  end

  localparam int CW = `SAP_CNT_W;

  // link-domain reset and enable, brought over from the system clock
  logic lrst_s1_reg;
  logic lrst_s2_reg;
  logic lce_s1_reg;
  logic lce_s2_reg;
  logic lrst_n;
  logic lce;

  always_ff @(posedge sck_link_i) begin
    lrst_s1_reg <= rst_n_i;
    lrst_s2_reg <= lrst_s1_reg;
    lce_s1_reg <= ce_i;
    lce_s2_reg <= lce_s1_reg;
  end

  assign lrst_n = lrst_s2_reg;
  assign lce = lce_s2_reg;

  // select sampling; ws and sd are launched by the master from this very
  // clock, so one rising-edge capture is the synchronous input stage
  logic ws_reg;
  logic ws_edge_reg;
  logic ws_live_reg;
  logic ws_trans;

  // no edge until one real sample is held, else reset fakes a toggle
  assign ws_trans = ws_live_reg && (ws_i != ws_reg);

  always_ff @(posedge sck_link_i) begin
    if (!lrst_n) begin
      ws_reg <= `SAP_WS_LEFT;
      ws_edge_reg <= 1'b0;
      ws_live_reg <= 1'b0;
    end else if (lce) begin
      ws_live_reg <= 1'b1;
      ws_reg <= ws_i;
      ws_edge_reg <= ws_trans;
    end
  end

  // receive shifter
  sap_pkg::sap_rx_state_type rx_state_reg;
  logic [RX_W-1:0] rx_shift_reg;
  logic [RX_W-1:0] rx_word_next;
  logic [CW-1:0] rx_cnt_reg;
  logic rx_src_busy;
  logic rx_src_valid;
  logic rx_drop_tgl_reg;

  always_comb begin
    rx_word_next = rx_shift_reg;
    // fill downward from the MSB; later bits fall away, missing ones stay 0
    if (int'(rx_cnt_reg) < RX_W) begin
      rx_word_next[RX_W-1-int'(rx_cnt_reg)] = sd_rx_i;
    end
  end

  // the bit captured on the edge that sees the transition is still the
  // LSB of the word that ends there
  assign rx_src_valid = lce && ws_trans && (rx_state_reg == sap_pkg::SAP_RX_RUN)
    && !rx_src_busy;

  always_ff @(posedge sck_link_i) begin
    if (!lrst_n) begin
      rx_state_reg <= sap_pkg::SAP_RX_HUNT;
      rx_shift_reg <= '0;
      rx_cnt_reg <= `SAP_CNT_RST;
    end else if (lce) begin
      case (rx_state_reg)
        sap_pkg::SAP_RX_HUNT: begin
          if (ws_trans) begin
            rx_state_reg <= sap_pkg::SAP_RX_RUN;
          end
          rx_shift_reg <= '0;
          rx_cnt_reg <= `SAP_CNT_RST;
        end
        sap_pkg::SAP_RX_RUN: begin
          if (ws_trans) begin
            rx_shift_reg <= '0;
            rx_cnt_reg <= `SAP_CNT_RST;
          end else if (int'(rx_cnt_reg) < RX_W) begin
            rx_shift_reg <= rx_word_next;
            rx_cnt_reg <= rx_cnt_reg + CW'(1);
          end
        end
        default: begin
          rx_state_reg <= sap_pkg::SAP_RX_HUNT;
        end
      endcase
    end
  end

  // a completed word meeting a busy crossing is lost; flagged to the system
  always_ff @(posedge sck_link_i) begin
    if (!lrst_n) begin
      rx_drop_tgl_reg <= 1'b0;
    end else if (lce && ws_trans && rx_state_reg == sap_pkg::SAP_RX_RUN && rx_src_busy) begin
      rx_drop_tgl_reg <= ~rx_drop_tgl_reg;
    end
  end

  // received word and its channel cross to the system clock
  logic rx_dst_valid;
  logic [RX_W:0] rx_dst_data;
  logic fifo_in_ready;

  sap_hs_cdc #(
    .WIDTH(RX_W + 1)
  ) u_rx_cdc (
    .src_clk_i(sck_link_i),
    .src_rst_n_i(lrst_n),
    .src_ce_i(lce),
    .src_valid_i(rx_src_valid),
    .src_data_i({ws_reg, rx_word_next}),
    .src_busy_o(rx_src_busy),
    .dst_clk_i(clk_sys_i),
    .dst_rst_n_i(rst_n_i),
    .dst_ce_i(ce_i),
    .dst_valid_o(rx_dst_valid),
    .dst_data_o(rx_dst_data),
    .dst_ready_i(fifo_in_ready)
  );

  // full buffer holds the crossing, which in turn makes the link drop
  logic fifo_out_valid;
  logic [RX_W:0] fifo_out_data;
  logic fifo_out_ready;

  sap_fifo #(
    .WIDTH(RX_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .in_valid_i(rx_dst_valid),
    .in_data_i(rx_dst_data),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(fifo_out_ready)
  );

  // registered output stage
  assign fifo_out_ready = ce_i && (!rx_valid_o || rx_ready_i);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o <= '0;
      rx_chan_o <= `SAP_WS_LEFT;
    end else if (fifo_out_ready) begin
      rx_valid_o <= fifo_out_valid;
      if (fifo_out_valid) begin
        rx_data_o <= fifo_out_data[RX_W-1:0];
        rx_chan_o <= fifo_out_data[RX_W];
      end
    end
  end

  // drop events to a one-cycle pulse
  logic drop_s1_reg;
  logic drop_s2_reg;
  logic drop_s3_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      drop_s1_reg <= 1'b0;
      drop_s2_reg <= 1'b0;
      drop_s3_reg <= 1'b0;
      rx_drop_o <= 1'b0;
    end else if (ce_i) begin
      drop_s1_reg <= rx_drop_tgl_reg;
      drop_s2_reg <= drop_s1_reg;
      drop_s3_reg <= drop_s2_reg;
      rx_drop_o <= drop_s2_reg ^ drop_s3_reg;
    end
  end

  // transmit words enter on the system clock
  logic tx_src_busy;
  logic tx_accept;

  assign tx_accept = ce_i && tx_valid_i && tx_ready_o;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_ready_o <= 1'b0;
    end else if (ce_i) begin
      // busy rises one cycle after an accept, so drop ready on the accept
      tx_ready_o <= !tx_src_busy && !tx_accept;
    end
  end

  logic tx_dst_valid;
  logic [TX_W:0] tx_dst_data;

  sap_hs_cdc #(
    .WIDTH(TX_W + 1)
  ) u_tx_cdc (
    .src_clk_i(clk_sys_i),
    .src_rst_n_i(rst_n_i),
    .src_ce_i(ce_i),
    .src_valid_i(tx_accept),
    .src_data_i({tx_chan_i, tx_data_i}),
    .src_busy_o(tx_src_busy),
    .dst_clk_i(sck_link_i),
    .dst_rst_n_i(lrst_n),
    .dst_ce_i(lce),
    .dst_valid_o(tx_dst_valid),
    .dst_data_o(tx_dst_data),
    .dst_ready_i(1'b1)
  );

  // one holding word per channel; an unrefreshed word is sent again
  logic [TX_W-1:0] tx_left_reg;
  logic [TX_W-1:0] tx_right_reg;

  always_ff @(posedge sck_link_i) begin
    if (!lrst_n) begin
      tx_left_reg <= '0;
      tx_right_reg <= '0;
    end else if (lce && tx_dst_valid) begin
      if (tx_dst_data[TX_W] == `SAP_WS_RIGHT) begin
        tx_right_reg <= tx_dst_data[TX_W-1:0];
      end else begin
        tx_left_reg <= tx_dst_data[TX_W-1:0];
      end
    end
  end

  // transmit shifter on the falling edge, half a period of setup for the
  // rising-edge receiver
  logic [TX_W-1:0] tx_shift_reg;
  logic [TX_W-1:0] tx_word;
  logic [CW-1:0] tx_cnt_reg;

  assign tx_word = (ws_reg == `SAP_WS_RIGHT) ? tx_right_reg : tx_left_reg;

  always_ff @(negedge sck_link_i) begin
    if (!lrst_n) begin
      sd_tx_o <= 1'b0;
      tx_shift_reg <= '0;
      tx_cnt_reg <= CW'(TX_W);
    end else if (lce) begin
      if (ws_edge_reg) begin
        sd_tx_o <= tx_word[TX_W-1];
        tx_shift_reg <= {tx_word[TX_W-2:0], 1'b0};
        tx_cnt_reg <= CW'(1);
      end else if (int'(tx_cnt_reg) < TX_W) begin
        sd_tx_o <= tx_shift_reg[TX_W-1];
        tx_shift_reg <= {tx_shift_reg[TX_W-2:0], 1'b0};
        tx_cnt_reg <= tx_cnt_reg + CW'(1);
      end else begin
        sd_tx_o <= 1'b0;
      end
    end
  end

endmodule

// >>> verification/sap_port_assertions.sv
/* Checker of the serial audio port's outputs.
   Assumes the far end masters the bit clock and select. */
`timescale 1ns/100ps

module sap_port_assertions #(
  parameter int RX_W = 16,
  parameter int TX_W = 16,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic sck_link_i,
  input wire logic ws_i,
  input wire logic sd_rx_i,
  input wire logic sd_tx_o,
  input wire logic rx_valid_o,
  input wire logic [RX_W-1:0] rx_data_o,
  input wire logic rx_chan_o,
  input wire logic rx_ready_i,
  input wire logic rx_drop_o,
  input wire logic tx_valid_i,
  input wire logic [TX_W-1:0] tx_data_i,
  input wire logic tx_chan_i,
  input wire logic tx_ready_o
);
  logic ws_q_reg;
  logic [5:0] bit_cnt_reg;

  always_ff @(posedge sck_link_i) begin
    ws_q_reg <= ws_i;
  end

  // bits since the last select change; saturates so idle stays quiet
  always_ff @(posedge sck_link_i) begin
    if (!rst_n_i)
      bit_cnt_reg <= 6'h3F;
    else if (ws_i != ws_q_reg)
      bit_cnt_reg <= 6'h00;
    else if (bit_cnt_reg != 6'h3F)
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
  end

  a_rx_hold_stable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o) && $stable(rx_chan_o))
    else $error("received word changed before it was taken");
  a_valid_until_taken: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(rx_valid_o) |-> $past(rx_ready_i))
    else $error("received word withdrawn without a take");
  a_drop_one_cycle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rx_drop_o |=> !rx_drop_o)
    else $error("drop flag longer than one cycle");
  a_reset_clear: assert property (@(posedge clk_sys_i)
    !rst_n_i |=> !rx_valid_o && !tx_ready_o && !rx_drop_o && rx_data_o == '0)
    else $error("outputs not cleared by reset");
  a_hunt_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> !rx_valid_o [*8])
    else $error("word delivered right after reset");
  a_tx_take_drop: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    tx_valid_i && tx_ready_o && ce_i |=> !tx_ready_o)
    else $error("transmit ready held after a take");
  a_tx_ready_back: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(tx_ready_o) |-> ##[1:300] tx_ready_o)
    else $error("transmit ready did not return");
  a_tx_pad_zero: assert property (@(posedge sck_link_i) disable iff (!rst_n_i)
    bit_cnt_reg >= TX_W |-> !sd_tx_o)
    else $error("transmit bit past word end not zero");
endmodule

bind sap_port sap_port_assertions #(.RX_W(RX_W), .TX_W(TX_W), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clk_sys_i, .rst_n_i, .ce_i, .sck_link_i, .ws_i, .sd_rx_i, .sd_tx_o, .rx_valid_o,
  .rx_data_o, .rx_chan_o, .rx_ready_i, .rx_drop_o, .tx_valid_i, .tx_data_i, .tx_chan_i,
  .tx_ready_o
);

// >>> verification/sap_master_model.sv
/* Link master model: bit clock, select, receive data, capture of transmit.
   Assumes the bench enables it after reset and sets the half length. */
`timescale 1ns/100ps

module sap_master_model (
  input wire logic en_i,
  input wire logic [5:0] half_i,
  input wire logic sd_tx_i,
  output logic sck_o,
  output logic ws_o,
  output logic sd_o,
  output logic [16:0] exp_o,
  output logic exp_t_o,
  output logic [31:0] cap_l_o,
  output logic [31:0] cap_r_o
);
  logic [31:0] sh = '0;
  logic [31:0] cap = '0;
  logic [15:0] n = '0;
  logic [15:0] w = '0;
  logic [15:0] nw;
  logic [5:0] cnt = '0;
  logic [5:0] h = 6'h10;
  logic [5:0] bc = '0;
  logic wsp = 1'b1;
  logic live = 1'b0;

  assign nw = n * 16'h03B5 ^ 16'h8421;

  initial begin
    sck_o = 1'b0;
    ws_o = 1'b1;
    sd_o = 1'b0;
    exp_o = '0;
    exp_t_o = 1'b0;
    cap_l_o = '0;
    cap_r_o = '0;
    #37;
    forever #80 sck_o = ~sck_o; // free-running bit clock
  end

  // launch on falling edges; select toggles with the last bit
  always @(negedge sck_o) begin
    sd_o <= sh[31];
    if (en_i && (cnt == h - 6'h01 || !live)) begin
      ws_o <= ~ws_o;
      sh <= {nw, n ^ 16'hC3A5}; // trailing bits beyond a 16-bit word
      w <= nw;
      n <= n + 16'h0001;
      cnt <= '0;
      h <= half_i;
      live <= 1'b1;
      if (live) begin
        exp_o <= {ws_o, h < 6'h10 ? w & (16'hFFFF << (6'h10 - h)) : w};
        exp_t_o <= ~exp_t_o;
      end
    end else begin
      sh <= {sh[30:0], 1'b0};
      cnt <= cnt + 6'h01;
    end
  end

  // capture on rising edges, word closes when select is seen to change
  always @(posedge sck_o) begin
    wsp <= ws_o;
    if (ws_o != wsp) begin
      if (wsp)
        cap_r_o <= {cap[30:0], sd_tx_i} << (6'h1F - bc);
      else
        cap_l_o <= {cap[30:0], sd_tx_i} << (6'h1F - bc);
      cap <= '0;
      bc <= '0;
    end else begin
      cap <= {cap[30:0], sd_tx_i};
      bc <= bc + 6'h01;
    end
  end
endmodule

// >>> verification/tb_serial_audio_port.sv
/* Self-checking bench of the serial audio port.
   Assumes the link master model drives clock, select and receive data. */
`timescale 1ns/100ps

module tb_serial_audio_port;
  typedef struct packed {
    logic [5:0] h;
    logic [15:0] tl;
    logic [15:0] tr;
    logic [31:0] el;
    logic [31:0] er;
  } sap_row_type;

  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic rx_ready_i = 1'b1;
  logic tx_valid_i = 1'b0;
  logic tx_chan_i = 1'b0;
  logic [15:0] tx_data_i = '0;
  logic en = 1'b0;
  logic [5:0] half = 6'h10;
  logic sck, ws, sd_rx, sd_tx, rx_valid_o, rx_chan_o, rx_drop_o, tx_ready_o, exp_t;
  logic [15:0] rx_data_o;
  logic [16:0] exp_w;
  logic [31:0] cap_l, cap_r;
  logic [16:0] q[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int skip = 0;
  int n_rx = 0;
  int i;
  // transmit word, frame half length and the left/right captures they give
  sap_row_type rows [4] = '{
    {6'h10, 16'h8001, 16'h7FFE, 32'h80010000, 32'h7FFE0000},
    {6'h18, 16'hA5C3, 16'h3C5A, 32'hA5C30000, 32'h3C5A0000},
    {6'h08, 16'hFFFF, 16'h0001, 32'hFF000000, 32'h00000000},
    {6'h14, 16'h1234, 16'hFEDC, 32'h12340000, 32'hFEDC0000}};

  sap_port dut (.clk_sys_i, .rst_n_i, .ce_i, .sck_link_i(sck), .ws_i(ws), .sd_rx_i(sd_rx),
    .sd_tx_o(sd_tx), .rx_valid_o, .rx_data_o, .rx_chan_o, .rx_ready_i, .rx_drop_o,
    .tx_valid_i, .tx_data_i, .tx_chan_i, .tx_ready_o);

  sap_master_model u_far (.en_i(en), .half_i(half), .sd_tx_i(sd_tx), .sck_o(sck), .ws_o(ws),
    .sd_o(sd_rx), .exp_o(exp_w), .exp_t_o(exp_t), .cap_l_o(cap_l), .cap_r_o(cap_r));

  always #2.5 clk_sys_i = ~clk_sys_i;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // hold the offer until ready is sampled high at an edge
  task automatic send(input logic c, input logic [15:0] d);
    int k;
    k = 0;
    tx_chan_i <= c;
    tx_data_i <= d;
    tx_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    while (tx_ready_o !== 1'b1 && k < 400) begin
      @(posedge clk_sys_i);
      k++;
    end
    chk("tx taken", 32'h1, {31'h0, tx_ready_o});
    tx_valid_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  always @(exp_t) begin
    if (en)
      q.push_back(exp_w);
  end

  // lost words may only be skipped after a drop pulse
  always @(posedge clk_sys_i) begin
    if (rx_drop_o === 1'b1)
      skip++;
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
      while (skip > 0 && q.size() > 1 && q[0] !== {rx_chan_o, rx_data_o}) begin
        void'(q.pop_front());
        skip--;
      end
      chk("rx word", q.size() > 0 ? q.pop_front() : 'x, {rx_chan_o, rx_data_o});
      n_rx++;
    end
  end

  initial begin
    #(60000 * 5);
    n_mismatch++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge clk_sys_i);
    repeat (3) @(posedge sck);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge sck);
    @(posedge clk_sys_i);
    en <= 1'b1;
    chk("rx valid", 32'h0, {31'h0, rx_valid_o});
    chk("tx ready", 32'h1, {31'h0, tx_ready_o});
    $display("reset test done");
    foreach (rows[r]) begin
      half <= rows[r].h;
      send(1'b0, rows[r].tl);
      send(1'b1, rows[r].tr);
      repeat (6 * rows[r].h) @(posedge sck);
      @(posedge clk_sys_i);
      chk("tx left", rows[r].el, cap_l);
      chk("tx right", rows[r].er, cap_r);
      $display("row %0d done", r);
    end
    chk("rx count", 32'h1, {31'h0, n_rx > 8});
    rx_ready_i <= 1'b0;
    i = 0;
    while (skip == 0 && i < 30000) begin
      @(posedge clk_sys_i);
      i++;
    end
    chk("drop seen", 32'h1, {31'h0, skip > 0});
    n_rx = 0;
    rx_ready_i <= 1'b1;
    repeat (2048) @(posedge clk_sys_i);
    chk("drained", 32'h1, {31'h0, n_rx >= 16});
    chk("backlog", 32'h1, {31'h0, q.size() <= 2});
    $display("buffer test done");
    rx_ready_i <= 1'b0;
    ce_i <= 1'b0;
    tx_chan_i <= 1'b0;
    tx_valid_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    chk("ce frozen ready", 32'h1, {31'h0, tx_ready_o});
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk("ce resumed take", 32'h0, {31'h0, tx_ready_o});
    tx_valid_i <= 1'b0;
    $display("enable test done");
    finish_test();
  end
endmodule
